// ---- logic/fprr_pkg.sv ----
/*
 * Shared constants for the feedback, page and reference rate-mode register slice:
 * register indices, reset values, write masks, field positions, page codes,
 * rate-mode codes, phase trim step and AXI4-Lite response codes.
 * Assumes it is compiled before every module that imports it.
 */
package fprr_pkg;

    // Bus geometry
    localparam int          FPRR_ADDR_W      = 12;
    localparam int          FPRR_DATA_W      = 32;
    localparam int          FPRR_REG_W       = 8;

    // Register indices; byte address is four times the index
    localparam logic [7:0]  IDX_FB_CTRL      = 8'h62;
    localparam logic [7:0]  IDX_PHASE_TRIM   = 8'h63;
    localparam logic [7:0]  IDX_PAGE_SEL     = 8'h64;
    localparam logic [7:0]  IDX_RATE_MODE_LO = 8'h65;
    localparam logic [7:0]  IDX_RATE_MODE_HI = 8'h66;
    localparam logic [7:0]  IDX_RATE_A_LO    = 8'h67;
    localparam logic [7:0]  IDX_RATE_A_HI    = 8'h68;
    localparam logic [7:0]  IDX_STATUS       = 8'h70;

    // Reset values
    localparam logic [7:0]  RST_FB_CTRL      = 8'h80;
    localparam logic [7:0]  RST_PHASE_TRIM   = 8'he5;
    localparam logic [7:0]  RST_PAGE_SEL     = 8'h00;
    localparam logic [7:0]  RST_RATE_MODE    = 8'h00;
    localparam logic [7:0]  RST_RATE_A       = 8'h00;

    // Writable bits; the rest hold their reset value
    localparam logic [7:0]  WMASK_FB_CTRL    = 8'h11;
    localparam logic [7:0]  WMASK_FULL       = 8'hff;
    localparam logic [7:0]  WMASK_RATE_A_HI  = 8'h3f;

    // Field positions
    localparam int          FB_CLK_EN_BIT    = 0;
    localparam int          FB_PIN_SEL_BIT   = 4;

    // Page codes
    localparam logic [7:0]  PAGE_GENERAL     = 8'h00;
    localparam logic [7:0]  PAGE_FREERUN     = 8'h01;
    localparam logic [7:0]  PAGE_EIGHTH_REF  = 8'h08;
    localparam logic [7:0]  PAGE_COMPOSITE   = 8'h0f;

    // Reference frequency handling codes
    typedef enum logic [1:0] {
        RATE_AUTO     = 2'h0,
        RATE_USER_A   = 2'h1,
        RATE_USER_B   = 2'h2,
        RATE_RESERVED = 2'h3
    } fprr_rate_e;

    // Phase trim step, in tenths of a picosecond (119.2 ps)
    localparam logic signed [18:0] TRIM_STEP_TENTH_PS = 19'sh004a8;
    // User rate A unit in kHz
    localparam logic [16:0] RATE_UNIT_KHZ    = 17'h00008;

    // AXI4-Lite responses
    localparam logic [1:0]  RESP_OKAY        = 2'h0;
    localparam logic [1:0]  RESP_DECERR      = 2'h3;

endpackage

// ---- logic/fprr_rate_decode.sv ----
/*
 * Decodes the eight 2-bit reference frequency-mode fields into one-hot
 * selections per reference and flags the reserved code.
 * Assumes the fields arrive packed, reference 0 in the low two bits.
 */
`timescale 1ns/10ps
module fprr_rate_decode
    import fprr_pkg::*;
#(
    parameter int NUM_REFS = 8
) (
    input  wire logic [2*NUM_REFS-1:0] modes_in,
    output logic      [NUM_REFS-1:0]   auto_detect_out,
    output logic      [NUM_REFS-1:0]   user_rate_a_out,
    output logic      [NUM_REFS-1:0]   user_rate_b_out,
    output logic      [NUM_REFS-1:0]   reserved_out
);

    // One decoder per reference field
    for (genvar i = 0; i < NUM_REFS; i++) begin : g_ref
        wire fprr_rate_e mode = fprr_rate_e'(modes_in[2*i +: 2]);
        assign auto_detect_out[i] = (mode == RATE_AUTO);
        assign user_rate_a_out[i] = (mode == RATE_USER_A);
        assign user_rate_b_out[i] = (mode == RATE_USER_B);
        // Reserved code selects nothing; flagged for software
        assign reserved_out[i]    = (mode == RATE_RESERVED);
    end

endmodule

// ---- logic/fprr_regs.sv ----
/*
 * Feedback pin selection, fine phase trim, extended page pointer and
 * reference frequency-mode registers behind an AXI4-Lite slave.
 * Assumes one 200 MHz clock, a synchronous active-high reset and shared
 * pins that arrive asynchronously to that clock.
 */
// Decided for this implementation: register access over AXI4-Lite.
`timescale 1ns/10ps
module fprr_regs
    import fprr_pkg::*;
#(
    parameter int NUM_REFS = 8
) (
    input  wire logic                     ref_clk_in,
    input  wire logic                     rst_in,
    // AXI4-Lite slave
    input  wire logic [FPRR_ADDR_W-1:0]   s_axi_awaddr_in,
    input  wire logic [2:0]               s_axi_awprot_in,
    input  wire logic                     s_axi_awvalid_in,
    output logic                          s_axi_awready_out,
    input  wire logic [FPRR_DATA_W-1:0]   s_axi_wdata_in,
    input  wire logic [3:0]               s_axi_wstrb_in,
    input  wire logic                     s_axi_wvalid_in,
    output logic                          s_axi_wready_out,
    output logic [1:0]                    s_axi_bresp_out,
    output logic                          s_axi_bvalid_out,
    input  wire logic                     s_axi_bready_in,
    input  wire logic [FPRR_ADDR_W-1:0]   s_axi_araddr_in,
    input  wire logic [2:0]               s_axi_arprot_in,
    input  wire logic                     s_axi_arvalid_in,
    output logic                          s_axi_arready_out,
    output logic [FPRR_DATA_W-1:0]        s_axi_rdata_out,
    output logic [1:0]                    s_axi_rresp_out,
    output logic                          s_axi_rvalid_out,
    input  wire logic                     s_axi_rready_in,
    // Shared pins
    input  wire logic                     shared_clk_pin_in,
    input  wire logic                     shared_frame_pin_in,
    // Routed pin functions
    output logic                          eighth_reference_input_out,
    output logic                          eighth_sync_input_out,
    output logic                          external_feedback_clock_out,
    output logic                          external_feedback_frame_pulse_out,
    output logic                          internal_feedback_out,
    output logic                          feedback_clock_enable_out,
    // Phase trim
    output logic [7:0]                    feedback_phase_trim_out,
    output logic signed [18:0]            phase_shift_tenth_ps_out,
    // Page selection
    output logic [7:0]                    page_select_out,
    output logic                          page_general_out,
    output logic                          page_freerun_out,
    output logic                          page_eighth_ref_out,
    output logic                          page_composite_out,
    output logic                          page_reserved_out,
    // Reference rate handling
    output logic [NUM_REFS-1:0]           auto_detect_out,
    output logic [NUM_REFS-1:0]           user_rate_a_out,
    output logic [NUM_REFS-1:0]           user_rate_b_out,
    output logic [13:0]                   user_rate_a_mult_out,
    output logic [16:0]                   user_rate_a_khz_out
);

    // Index of a word address; unaligned or out-of-range gives an unmapped index
    function automatic logic [7:0] word_index(input logic [FPRR_ADDR_W-1:0] addr);
        logic ok;
        ok = (addr[1:0] == 2'h0) && (addr[FPRR_ADDR_W-1:10] == '0);
        return ok ? addr[9:2] : 8'hff;
    endfunction

    // Writable registers of the slice
    function automatic logic is_writable(input logic [7:0] idx);
        return (idx >= IDX_FB_CTRL) && (idx <= IDX_RATE_A_HI);
    endfunction

    // Mapped for reading: writable ones plus status
    function automatic logic is_readable(input logic [7:0] idx);
        return is_writable(idx) || (idx == IDX_STATUS);
    endfunction

    // Merge new data into a register, keeping reserved bits at reset
    function automatic logic [7:0] merge(input logic [7:0] old_v, input logic [7:0] new_v,
                                         input logic [7:0] wmask);
        return (old_v & ~wmask) | (new_v & wmask);
    endfunction

    logic [7:0]             fb_ctrl_q;
    logic [7:0]             phase_trim_q;
    logic [7:0]             page_sel_q;
    logic [7:0]             rate_mode_lo_q;
    logic [7:0]             rate_mode_hi_q;
    logic [7:0]             rate_a_lo_q;
    logic [7:0]             rate_a_hi_q;

    logic                   aw_held_q;
    logic                   w_held_q;
    logic [FPRR_ADDR_W-1:0] aw_addr_q;
    logic [7:0]             w_data_q;
    logic                   w_lane0_q;
    logic                   bvalid_q;
    logic [1:0]             bresp_q;
    logic                   rvalid_q;
    logic [7:0]             rdata_q;
    logic [1:0]             rresp_q;

    logic                   clk_meta_q;
    logic                   clk_sync_q;
    logic                   frame_meta_q;
    logic                   frame_sync_q;

    logic                   eighth_reference_input_q;
    logic                   eighth_sync_input_q;
    logic                   ext_clk_q;
    logic                   ext_fp_q;
    logic signed [18:0]     shift_q;
    logic [16:0]            rate_khz_q;

    // Write channel handshake: each channel is taken once, response after both
    wire                    aw_take   = s_axi_awvalid_in && s_axi_awready_out;
    wire                    w_take    = s_axi_wvalid_in && s_axi_wready_out;
    wire                    aw_have   = aw_held_q || aw_take;
    wire                    w_have    = w_held_q || w_take;
    wire                    do_write  = aw_have && w_have && !bvalid_q;
    wire [FPRR_ADDR_W-1:0]  wr_addr   = aw_take ? s_axi_awaddr_in : aw_addr_q;
    wire [7:0]              wr_data   = w_take ? s_axi_wdata_in[7:0] : w_data_q;
    wire                    wr_lane0  = w_take ? s_axi_wstrb_in[0] : w_lane0_q;
    wire [7:0]              wr_idx    = word_index(wr_addr);
    wire                    wr_hit    = is_writable(wr_idx);
    wire                    wr_commit = do_write && wr_hit && wr_lane0;

    assign s_axi_awready_out = !aw_held_q && !bvalid_q;
    assign s_axi_wready_out  = !w_held_q && !bvalid_q;
    assign s_axi_bvalid_out  = bvalid_q;
    assign s_axi_bresp_out   = bresp_q;

    // Read channel: one read in flight, answered the cycle after it is taken
    wire                    ar_take   = s_axi_arvalid_in && s_axi_arready_out;
    wire [7:0]              rd_idx    = word_index(s_axi_araddr_in);

    assign s_axi_arready_out = !rvalid_q;
    assign s_axi_rvalid_out  = rvalid_q;
    assign s_axi_rdata_out   = {24'h000000, rdata_q};
    assign s_axi_rresp_out   = rresp_q;

    // Reference mode decode
    logic [NUM_REFS-1:0]    rsvd_mode;

    fprr_rate_decode #(
        .NUM_REFS        (NUM_REFS)
    ) u_rate_decode (
        .modes_in        ({rate_mode_hi_q, rate_mode_lo_q}),
        .auto_detect_out (auto_detect_out),
        .user_rate_a_out (user_rate_a_out),
        .user_rate_b_out (user_rate_b_out),
        .reserved_out    (rsvd_mode)
    );

    // Live status word, built from the block's own state
    wire                    pin_sel   = fb_ctrl_q[FB_PIN_SEL_BIT];
    wire [7:0]              status_v  = {4'h0, frame_sync_q, clk_sync_q, |rsvd_mode, pin_sel};

    // Read data selection
    logic [7:0] rd_value;
    always_comb begin
        case (rd_idx)
            IDX_FB_CTRL:      rd_value = fb_ctrl_q;
            IDX_PHASE_TRIM:   rd_value = phase_trim_q;
            IDX_PAGE_SEL:     rd_value = page_sel_q;
            IDX_RATE_MODE_LO: rd_value = rate_mode_lo_q;
            IDX_RATE_MODE_HI: rd_value = rate_mode_hi_q;
            IDX_RATE_A_LO:    rd_value = rate_a_lo_q;
            IDX_RATE_A_HI:    rd_value = rate_a_hi_q;
            IDX_STATUS:       rd_value = status_v;
            default:          rd_value = 8'h00;
        endcase
    end

    // Write side of the bus slave
    always_ff @(posedge ref_clk_in) begin
        if (rst_in) begin
            aw_held_q <= 1'b0;
            w_held_q  <= 1'b0;
            aw_addr_q <= '0;
            w_data_q  <= 8'h00;
            w_lane0_q <= 1'b0;
            bvalid_q  <= 1'b0;
            bresp_q   <= RESP_OKAY;
        end else begin
            if (aw_take) begin
                aw_addr_q <= s_axi_awaddr_in;
            end
            if (w_take) begin
                w_data_q  <= s_axi_wdata_in[7:0];
                w_lane0_q <= s_axi_wstrb_in[0];
            end
            if (do_write) begin
                aw_held_q <= 1'b0;
                w_held_q  <= 1'b0;
                bvalid_q  <= 1'b1;
                bresp_q   <= wr_hit ? RESP_OKAY : RESP_DECERR;
            end else begin
                aw_held_q <= aw_have;
                w_held_q  <= w_have;
                if (s_axi_bready_in) begin
                    bvalid_q <= 1'b0;
                end
            end
        end
    end

    // Configuration registers; a write with byte lane 0 off changes nothing
    always_ff @(posedge ref_clk_in) begin
        if (rst_in) begin
            fb_ctrl_q      <= RST_FB_CTRL;
            phase_trim_q   <= RST_PHASE_TRIM;
            page_sel_q     <= RST_PAGE_SEL;
            rate_mode_lo_q <= RST_RATE_MODE;
            rate_mode_hi_q <= RST_RATE_MODE;
            rate_a_lo_q    <= RST_RATE_A;
            rate_a_hi_q    <= RST_RATE_A;
        end else if (wr_commit) begin
            case (wr_idx)
                IDX_FB_CTRL:      fb_ctrl_q      <= merge(fb_ctrl_q, wr_data, WMASK_FB_CTRL);
                IDX_PHASE_TRIM:   phase_trim_q   <= wr_data;
                IDX_PAGE_SEL:     page_sel_q     <= wr_data;
                IDX_RATE_MODE_LO: rate_mode_lo_q <= wr_data;
                IDX_RATE_MODE_HI: rate_mode_hi_q <= wr_data;
                IDX_RATE_A_LO:    rate_a_lo_q    <= wr_data;
                IDX_RATE_A_HI:    rate_a_hi_q    <= merge(rate_a_hi_q, wr_data, WMASK_RATE_A_HI);
                default:          page_sel_q     <= page_sel_q;
            endcase
        end
    end

    // Read side of the bus slave
    always_ff @(posedge ref_clk_in) begin
        if (rst_in) begin
            rvalid_q <= 1'b0;
            rdata_q  <= 8'h00;
            rresp_q  <= RESP_OKAY;
        end else if (ar_take) begin
            rvalid_q <= 1'b1;
            rdata_q  <= rd_value;
            rresp_q  <= is_readable(rd_idx) ? RESP_OKAY : RESP_DECERR;
        end else if (s_axi_rready_in) begin
            rvalid_q <= 1'b0;
        end
    end

    // Two-stage synchronisers; the pins are asynchronous to ref_clk_in.
    // Sampling limits usable pin rates to well under half the clock rate.
    always_ff @(posedge ref_clk_in) begin
        if (rst_in) begin
            clk_meta_q   <= 1'b0;
            clk_sync_q   <= 1'b0;
            frame_meta_q <= 1'b0;
            frame_sync_q <= 1'b0;
        end else begin
            clk_meta_q   <= shared_clk_pin_in;
            clk_sync_q   <= clk_meta_q;
            frame_meta_q <= shared_frame_pin_in;
            frame_sync_q <= frame_meta_q;
        end
    end

    // Pin routing: the unselected function is held low so it never sees stray edges
    always_ff @(posedge ref_clk_in) begin
        if (rst_in) begin
            eighth_reference_input_q    <= 1'b0;
            eighth_sync_input_q   <= 1'b0;
            ext_clk_q <= 1'b0;
            ext_fp_q  <= 1'b0;
        end else begin
            eighth_reference_input_q    <= !pin_sel && clk_sync_q;
            eighth_sync_input_q   <= !pin_sel && frame_sync_q;
            ext_clk_q <= pin_sel && clk_sync_q;
            ext_fp_q  <= pin_sel && frame_sync_q;
        end
    end

    assign eighth_reference_input_out        = eighth_reference_input_q;
    assign eighth_sync_input_out             = eighth_sync_input_q;
    assign external_feedback_clock_out       = ext_clk_q;
    assign external_feedback_frame_pulse_out = ext_fp_q;
    assign internal_feedback_out             = !fb_ctrl_q[FB_PIN_SEL_BIT];
    assign feedback_clock_enable_out         = fb_ctrl_q[FB_CLK_EN_BIT];

    // Signed trim scaled to tenths of a picosecond; registered to keep the multiply off the path
    always_ff @(posedge ref_clk_in) begin
        if (rst_in) begin
            shift_q    <= 19'sh00000;
            rate_khz_q <= 17'h00000;
        end else begin
            shift_q    <= $signed(phase_trim_q) * TRIM_STEP_TENTH_PS;
            rate_khz_q <= 17'({rate_a_hi_q[5:0], rate_a_lo_q}) * RATE_UNIT_KHZ;
        end
    end

    assign feedback_phase_trim_out  = phase_trim_q;
    assign phase_shift_tenth_ps_out = shift_q;
    assign user_rate_a_mult_out     = {rate_a_hi_q[5:0], rate_a_lo_q};
    assign user_rate_a_khz_out      = rate_khz_q;

    // Page decode; unlisted codes select no page
    assign page_select_out     = page_sel_q;
    assign page_general_out    = (page_sel_q == PAGE_GENERAL);
    assign page_freerun_out    = (page_sel_q == PAGE_FREERUN);
    assign page_eighth_ref_out = (page_sel_q == PAGE_EIGHTH_REF);
    assign page_composite_out  = (page_sel_q == PAGE_COMPOSITE);
    assign page_reserved_out   = !(page_general_out || page_freerun_out ||
                                   page_eighth_ref_out || page_composite_out);

endmodule

// ---- dv/fprr_regs_chk.sv ----
/*
 * Concurrent checks on the ports of the register slice: pin routing, trim
 * scaling, page decode, rate decode and bus answer timing.
 * Assumes one clock and a synchronous active-high reset; attached by bind.
 */
`timescale 1ns/10ps
module fprr_regs_chk
    import fprr_pkg::*;
#(
    parameter int NUM_REFS = 8
) (
    input  wire logic                ref_clk_in,
    input  wire logic                rst_in,
    input  wire logic [1:0]          s_axi_bresp_out,
    input  wire logic                s_axi_bvalid_out,
    input  wire logic                s_axi_bready_in,
    input  wire logic                s_axi_arvalid_in,
    input  wire logic                s_axi_arready_out,
    input  wire logic                s_axi_rvalid_out,
    input  wire logic                eighth_reference_input_out,
    input  wire logic                eighth_sync_input_out,
    input  wire logic                external_feedback_clock_out,
    input  wire logic                external_feedback_frame_pulse_out,
    input  wire logic                internal_feedback_out,
    input  wire logic [7:0]          feedback_phase_trim_out,
    input  wire logic signed [18:0]  phase_shift_tenth_ps_out,
    input  wire logic [7:0]          page_select_out,
    input  wire logic                page_general_out,
    input  wire logic                page_freerun_out,
    input  wire logic                page_eighth_ref_out,
    input  wire logic                page_composite_out,
    input  wire logic                page_reserved_out,
    input  wire logic [NUM_REFS-1:0] auto_detect_out,
    input  wire logic [NUM_REFS-1:0] user_rate_a_out,
    input  wire logic [NUM_REFS-1:0] user_rate_b_out,
    input  wire logic [13:0]         user_rate_a_mult_out,
    input  wire logic [16:0]         user_rate_a_khz_out
);
    // Single domain, so clock and reset are given once
    default clocking cb @(posedge ref_clk_in); endclocking
    default disable iff (rst_in);

    // Route registers lag the select by one edge, so both samples must agree
    internal_route_a: assert property (internal_feedback_out && $past(internal_feedback_out) |->
        !external_feedback_clock_out && !external_feedback_frame_pulse_out) else $error("ext live");
    external_route_a: assert property (!internal_feedback_out && !$past(internal_feedback_out) |->
        !eighth_reference_input_out && !eighth_sync_input_out) else $error("eighth_reference_input live");
    trim_scale_a: assert property (!$past(rst_in) |-> phase_shift_tenth_ps_out ==
        $signed($past(feedback_phase_trim_out)) * 19'sd1192) else $error("trim scale wrong");
    page_low_a: assert property (page_general_out == (page_select_out == PAGE_GENERAL) &&
        page_freerun_out == (page_select_out == PAGE_FREERUN)) else $error("page decode low");
    page_eighth_a: assert property (page_eighth_ref_out == (page_select_out == PAGE_EIGHTH_REF))
        else $error("page 08 decode");
    page_comp_a: assert property (page_composite_out == (page_select_out == PAGE_COMPOSITE) &&
        page_reserved_out == !(page_general_out || page_freerun_out || page_eighth_ref_out ||
        page_composite_out)) else $error("page 0f decode");
    rate_excl_a: assert property ((auto_detect_out & user_rate_a_out) == '0 &&
        (auto_detect_out & user_rate_b_out) == '0 && (user_rate_a_out & user_rate_b_out) == '0)
        else $error("rate modes overlap");
    rate_khz_a: assert property (!$past(rst_in) |-> user_rate_a_khz_out ==
        $past(user_rate_a_mult_out) * 17'd8) else $error("rate a khz wrong");
    page_hold_a: assert property ($changed(page_select_out) |-> $rose(s_axi_bvalid_out))
        else $error("page moved without write");
    read_answer_a: assert property (s_axi_arvalid_in && s_axi_arready_out |=> s_axi_rvalid_out)
        else $error("read not answered");
    bresp_hold_a: assert property (s_axi_bvalid_out && !s_axi_bready_in |=>
        s_axi_bvalid_out && $stable(s_axi_bresp_out)) else $error("write answer dropped");

    // Main scenarios
    ext_seen_c: cover property (external_feedback_clock_out);
    page_comp_c: cover property (page_composite_out);
    user_b_c: cover property (user_rate_b_out != '0);
endmodule
// Every checker port carries the name of the design port it watches
bind fprr_regs fprr_regs_chk #(.NUM_REFS(NUM_REFS)) fprr_regs_chk_i (.*);

// ---- dv/fprr_regs_test.sv ----
/*
 * Self-checking bench for the register slice: reset values, pin routing,
 * trim scaling, page decode, rate decode and unmapped access.
 * Assumes package and design compile first; the bench is the bus master.
 */
`timescale 1ns/10ps
module fprr_regs_test import fprr_pkg::*;;
    logic clk = 1'b0, rst = 1'b1, awv = 1'b0, wv = 1'b0, br = 1'b0, arv = 1'b0, rr = 1'b0;
    logic pc = 1'b0, pf = 1'b0, awr, wr_rdy, bv, arr, rv, e8r, e8s, exc, exf, intf, fce;
    logic pg0, pg1, pg8, pgf, pgr;
    logic [11:0] awa = 12'h000, ara = 12'h000;
    logic [31:0] wd = 32'h0, rdat;
    logic [3:0] ws = 4'h0;
    logic [1:0] bresp, rresp, r;
    logic [7:0] trim, psel, auto, ua, ub;
    logic signed [18:0] psh;
    logic [13:0] mult;
    logic [16:0] khz;
    logic [31:0] d;
    int fails = 0, cmp_count = 0, cyc = 0;

    fprr_regs #(.NUM_REFS(8)) fprr_regs_i (.ref_clk_in(clk), .rst_in(rst),
        .s_axi_awaddr_in(awa), .s_axi_awprot_in(3'h0), .s_axi_awvalid_in(awv),
        .s_axi_awready_out(awr), .s_axi_wdata_in(wd), .s_axi_wstrb_in(ws), .s_axi_wvalid_in(wv),
        .s_axi_wready_out(wr_rdy), .s_axi_bresp_out(bresp), .s_axi_bvalid_out(bv),
        .s_axi_bready_in(br), .s_axi_araddr_in(ara), .s_axi_arprot_in(3'h0),
        .s_axi_arvalid_in(arv), .s_axi_arready_out(arr), .s_axi_rdata_out(rdat),
        .s_axi_rresp_out(rresp), .s_axi_rvalid_out(rv), .s_axi_rready_in(rr),
        .shared_clk_pin_in(pc), .shared_frame_pin_in(pf), .eighth_reference_input_out(e8r),
        .eighth_sync_input_out(e8s), .external_feedback_clock_out(exc),
        .external_feedback_frame_pulse_out(exf), .internal_feedback_out(intf),
        .feedback_clock_enable_out(fce), .feedback_phase_trim_out(trim),
        .phase_shift_tenth_ps_out(psh), .page_select_out(psel), .page_general_out(pg0),
        .page_freerun_out(pg1), .page_eighth_ref_out(pg8), .page_composite_out(pgf),
        .page_reserved_out(pgr), .auto_detect_out(auto), .user_rate_a_out(ua),
        .user_rate_b_out(ub), .user_rate_a_mult_out(mult), .user_rate_a_khz_out(khz));

    // 200 MHz clock
    always #2.5 clk = ~clk;

    // Guard against a slave that never answers
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            fails++;
            close_out();
        end
    end

    function automatic logic [11:0] A(input logic [7:0] i);
        return {2'h0, i, 2'h0};
    endfunction

    task automatic close_out();
        $display("compares %0d mismatches %0d", cmp_count, fails);
        if (fails == 0 && cmp_count > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask

    task automatic chk_val(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            fails++;
            $display("wrong value at %0t got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic chk_resp(input logic [1:0] got, input logic [1:0] exp);
        chk_val({30'h0, got}, {30'h0, exp});
    endtask

    // Handshakes judged at the falling edge
    task automatic wr(input logic [11:0] a, input logic [7:0] v, output logic [1:0] res);
        logic ta, tw, tb;
        @(posedge clk);
        {ta, tw, tb} = 3'h0;
        awa <= a; wd <= {24'h0, v}; ws <= 4'hf; awv <= 1'b1; wv <= 1'b1;
        while (!tb) begin
            @(negedge clk);
            ta = awv && (awr === 1'b1);
            tw = wv && (wr_rdy === 1'b1);
            tb = (bv === 1'b1);
            res = bresp;
            @(posedge clk);
            if (ta) awv <= 1'b0;
            if (tw) wv <= 1'b0;
            if (tb) br <= 1'b1;
        end
        // Answer left waiting one cycle so its hold is exercised
        @(posedge clk);
        br <= 1'b0;
    endtask

    task automatic rd(input logic [11:0] a, output logic [31:0] v, output logic [1:0] res);
        logic ta, tr;
        @(posedge clk);
        {ta, tr} = 2'h0;
        ara <= a; arv <= 1'b1; rr <= 1'b1;
        while (!tr) begin
            @(negedge clk);
            ta = arv && (arr === 1'b1);
            tr = (rv === 1'b1);
            v = rdat;
            res = rresp;
            @(posedge clk);
            if (ta) arv <= 1'b0;
            if (tr) rr <= 1'b0;
        end
    endtask

    task automatic wrok(input logic [7:0] i, input logic [7:0] v);
        wr(A(i), v, r);
        chk_resp(r, RESP_OKAY);
    endtask

    task automatic rdchk(input logic [7:0] i, input logic [7:0] exp);
        rd(A(i), d, r);
        chk_resp(r, RESP_OKAY);
        chk_val(d, {24'h0, exp});
    endtask

    task automatic t_reset();
        logic [7:0] ri [5] = '{IDX_FB_CTRL, IDX_PHASE_TRIM, IDX_PAGE_SEL, IDX_RATE_MODE_LO,
                               IDX_RATE_MODE_HI};
        logic [7:0] rv0 [5] = '{8'h80, 8'he5, 8'h00, 8'h00, 8'h00};
        for (int k = 0; k < 5; k++) rdchk(ri[k], rv0[k]);
        chk_val({31'h0, intf}, 32'h1);
        chk_val(32'(psh), 32'(-27 * 1192));
        $display("test reset done");
    endtask

    task automatic t_pins();
        wrok(IDX_FB_CTRL, 8'hff);
        rdchk(IDX_FB_CTRL, 8'h91);
        @(posedge clk);
        pc <= 1'b1; pf <= 1'b1;
        repeat (4) @(posedge clk);
        @(negedge clk);
        chk_val({28'h0, exc, exf, e8r, e8s | intf}, 32'hc);
        chk_val({31'h0, fce}, 32'h1);
        rdchk(IDX_STATUS, 8'h0d);
        wrok(IDX_FB_CTRL, 8'h00);
        repeat (4) @(posedge clk);
        @(negedge clk);
        chk_val({28'h0, exc, exf, e8r, e8s & intf}, 32'h3);
        rdchk(IDX_FB_CTRL, 8'h80);
        $display("test pins done");
    endtask

    task automatic t_trim();
        logic [7:0] tv [4] = '{8'h7f, 8'h80, 8'h00, 8'hff};
        foreach (tv[k]) begin
            wrok(IDX_PHASE_TRIM, tv[k]);
            repeat (2) @(posedge clk);
            @(negedge clk);
            chk_val(32'(psh), 32'($signed(tv[k]) * 1192));
            rdchk(IDX_PHASE_TRIM, tv[k]);
        end
        $display("test trim done");
    endtask

    task automatic t_page();
        logic [7:0] pv [5] = '{8'h00, 8'h01, 8'h08, 8'h0f, 8'h05};
        foreach (pv[k]) begin
            wrok(IDX_PAGE_SEL, pv[k]);
            chk_val({27'h0, pg0, pg1, pg8, pgf, pgr}, {27'h0, pv[k] == 8'h00, pv[k] == 8'h01,
                pv[k] == 8'h08, pv[k] == 8'h0f, k == 4});
        end
        wrok(IDX_PHASE_TRIM, 8'h00);
        rdchk(IDX_PAGE_SEL, 8'h05);
        $display("test page done");
    endtask

    task automatic t_rate();
        wrok(IDX_RATE_MODE_HI, 8'h24);
        for (int c = 0; c < 3; c++) begin
            wrok(IDX_RATE_MODE_LO, {4{c[1:0]}});
            chk_val({auto, ua, ub}, {4'h9, {4{c == 0}}, 4'h2, {4{c == 1}}, 4'h4, {4{c == 2}}});
            rdchk(IDX_RATE_MODE_LO, {4{c[1:0]}});
        end
        wrok(IDX_RATE_A_LO, 8'hff);
        wrok(IDX_RATE_A_HI, 8'hff);
        rdchk(IDX_RATE_A_HI, 8'h3f);
        repeat (2) @(posedge clk);
        @(negedge clk);
        chk_val({mult, 1'b0, khz}, {14'h3fff, 1'b0, 17'h1fff8});
        $display("test rate done");
    endtask

    task automatic t_unmapped();
        wr(12'h400, 8'h5a, r);
        chk_resp(r, RESP_DECERR);
        wr(A(IDX_STATUS), 8'h5a, r);
        chk_resp(r, RESP_DECERR);
        rd(12'h3fc, d, r);
        chk_resp(r, RESP_DECERR);
        chk_val(d, 32'h0);
        $display("test unmapped done");
    endtask

    // Reset for three cycles, then each scenario in turn
    initial begin
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        t_reset();
        t_pins();
        t_trim();
        t_page();
        t_rate();
        t_unmapped();
        close_out();
    end
endmodule
